// >>> rtl/uart_pkg.sv
// Package of register offsets, field positions, reset values and timing
// constants for the serial channel.
// Assumes a 32-bit classic Wishbone register bus, one register per word.
package uart_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_DATA = 5'h00;
  localparam logic [4:0] ADDR_IER = 5'h04;
  localparam logic [4:0] ADDR_IIR = 5'h08;
  localparam logic [4:0] ADDR_LCR = 5'h0c;
  localparam logic [4:0] ADDR_MCR = 5'h10;
  localparam logic [4:0] ADDR_LSR = 5'h14;
  localparam logic [4:0] ADDR_MSR = 5'h18;
  localparam logic [4:0] ADDR_SCR = 5'h1c;
  localparam int ADDR_MSB = 4;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  localparam int LCR_DLAB = 7;
  localparam int LCR_BREAK = 6;
  localparam int LCR_PEN = 3;
  localparam int LCR_STB = 2;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_USER_OUTPUT_ONE_N = 2;
  localparam int MCR_USER_OUTPUT_TWO_N = 3;
  localparam int MCR_LOOP = 4;
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_FE = 3;
  localparam int LSR_TX_HOLDING_EMPTY_FLAG = 5;
  localparam int LSR_TX_ALL_EMPTY_FLAG = 6;

  // ----------------------------------------------------------------------
  // Reset values and fixed codes.
  // ----------------------------------------------------------------------
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [4:0] LSR_ERR_RESET = 5'h00;
  localparam logic [3:0] MSR_DELTA_RESET = 4'h0;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [2:0] IIR_NONE = 3'h1;
  localparam logic [2:0] IIR_LINE = 3'h6;
  localparam logic [2:0] IIR_RXDATA = 3'h4;
  localparam logic [2:0] IIR_TX_HOLDING_EMPTY_FLAG = 3'h2;
  localparam logic [2:0] IIR_MODEM = 3'h0;

  // ----------------------------------------------------------------------
  // Baud generation.
  // ----------------------------------------------------------------------
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] MID_SAMPLE = 4'h7;

endpackage

// >>> rtl/baud_if.sv
// Interface between the channel core and its baud generator.
// Assumes both ends run on clk_i.
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
  logic [15:0] divisor;
  logic restart;
  logic tick;
  modport core (output divisor, output restart, input tick);
  modport gen (input divisor, input restart, output tick);
endinterface
`default_nettype wire

// >>> rtl/baud_gen.sv
// Baud generator that gives one tick per divisor cycles of the clock.
// Assumes the divisor is stable while the channel is in use.
`timescale 1ns/1ps
`default_nettype none
module baud_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  baud_if.gen bus
);

  logic [15:0] count_reg;

  // Count up to the divisor; a divisor of one ticks on every edge.
  always_ff @(posedge clk_i) begin
    if (rst_i || bus.restart) begin
      count_reg <= 16'h0000;
    end else if (count_reg + 16'h0001 >= bus.divisor) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // One tick at sixteen times the bit rate.
  assign bus.tick = !rst_i && !bus.restart &&
                    (count_reg + 16'h0001 >= bus.divisor);

endmodule // baud_gen
`default_nettype wire

// >>> rtl/uart_channel.sv
// One asynchronous serial channel with modem controls behind a Wishbone
// slave. Assumes synchronous pins and a single clock clk_i.
`timescale 1ns/1ps
`default_nettype none
module uart_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic serial_rx_line_i,
  output logic serial_tx_line_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic dcd_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic user_output_one_n_o,
  output logic user_output_two_n_o,
  output logic intr_o
);

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  logic [3:0] interrupt_enable_reg;
  logic [7:0] line_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] scratch_reg;
  logic [15:0] divisor_reg;
  logic [7:0] receive_buffer_reg;
  logic [7:0] transmit_holding_reg;
  logic tx_holding_empty_flag_reg;
  logic tx_all_empty_flag_reg;
  logic [4:0] line_err_reg;
  logic [3:0] msr_delta_reg;
  logic [3:0] modem_prev_reg;
  logic tx_holding_empty_flag_int_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  logic [3:0] modem_live;
  logic req;
  logic wr;
  logic rd;
  logic mapped;
  logic [4:0] addr;
  logic dlab;
  logic wr_data;
  logic rd_data;
  logic rd_iir;
  logic rd_lsr;
  logic rd_msr;
  logic [7:0] lsr_value;
  logic [7:0] msr_value;
  logic [7:0] iir_value;
  logic [2:0] iir_code;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_frame_err;
  logic tx_load;
  logic tx_idle;
  logic [7:0] byte_mask;

  baud_if baud ();

  baud_gen u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(baud.gen)
  );

  assign baud.divisor = divisor_reg;
  assign baud.restart = 1'b0;

  // ----------------------------------------------------------------------
  // Wishbone decode; one wait state, answer in the cycle after the request.
  // ----------------------------------------------------------------------
  assign addr = wb_adr_i[uart_pkg::ADDR_MSB:0];
  assign req = wb_cyc_i && wb_stb_i && !ack_reg && wb_sel_i[0];
  assign mapped = (wb_adr_i[31:uart_pkg::ADDR_MSB + 1] == '0) && (addr[1:0] == 2'b00);
  assign wr = req && mapped && wb_we_i;
  assign rd = req && mapped && !wb_we_i;
  assign dlab = line_control_reg[uart_pkg::LCR_DLAB];
  assign wr_data = wr && addr == uart_pkg::ADDR_DATA && !dlab;
  assign rd_data = rd && addr == uart_pkg::ADDR_DATA && !dlab;
  assign rd_iir = rd && addr == uart_pkg::ADDR_IIR;
  assign rd_lsr = rd && addr == uart_pkg::ADDR_LSR;
  assign rd_msr = rd && addr == uart_pkg::ADDR_MSR;

  // Acknowledge mapped accesses, flag an error for everything else.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      ack_reg <= req && mapped;
      wb_err_o <= wb_cyc_i && wb_stb_i && !ack_reg && !wb_err_o && !(mapped && wb_sel_i[0]);
    end
  end
  assign wb_ack_o = ack_reg;

  // ----------------------------------------------------------------------
  // Control registers written by software.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_enable_reg <= uart_pkg::IER_RESET;
      line_control_reg <= uart_pkg::LCR_RESET;
      modem_control_reg <= uart_pkg::MCR_RESET;
    end else if (wr) begin
      if (addr == uart_pkg::ADDR_IER && !dlab) begin
        interrupt_enable_reg <= wb_dat_i[3:0];
      end
      if (addr == uart_pkg::ADDR_LCR) begin
        line_control_reg <= wb_dat_i[7:0];
      end
      if (addr == uart_pkg::ADDR_MCR) begin
        modem_control_reg <= {3'h0, wb_dat_i[4:0]};
      end
    end
  end

  // Divisor latch is reloaded by reset only while it holds zero; scratch is untouched by reset.
  always_ff @(posedge clk_i) begin
    if (rst_i && divisor_reg == 16'h0000) begin
      divisor_reg <= uart_pkg::DIV_RESET;
    end else if (wr && dlab && addr == uart_pkg::ADDR_DATA) begin
      divisor_reg[7:0] <= wb_dat_i[7:0];
    end else if (wr && dlab && addr == uart_pkg::ADDR_IER) begin
      divisor_reg[15:8] <= wb_dat_i[7:0];
    end
  end

  // Scratch register for software use.
  always_ff @(posedge clk_i) begin
    if (wr && addr == uart_pkg::ADDR_SCR) begin
      scratch_reg <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Serial engine and line status.
  // ----------------------------------------------------------------------
  assign byte_mask = 8'hff;

  uart_shift u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(baud.tick),
    .rx_i(modem_control_reg[uart_pkg::MCR_LOOP] ? serial_tx_line_o : serial_rx_line_i),
    .load_i(tx_load),
    .data_i(transmit_holding_reg),
    .brk_i(line_control_reg[uart_pkg::LCR_BREAK]),
    .tx_o(serial_tx_line_o),
    .idle_o(tx_idle),
    .done_o(rx_done),
    .byte_o(rx_byte),
    .ferr_o(rx_frame_err)
  );

  assign tx_load = !tx_holding_empty_flag_reg && tx_idle && !wr_data;

  // Transmit holding flags; reset sets both empty flags.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_holding_empty_flag_reg <= 1'b1;
      tx_all_empty_flag_reg <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_holding_empty_flag_reg <= 1'b0;
      end else if (tx_load) begin
        tx_holding_empty_flag_reg <= 1'b1;
      end
      tx_all_empty_flag_reg <= tx_idle && tx_holding_empty_flag_reg && !wr_data;
    end
  end

  // Holding and receive buffers keep contents through reset.
  always_ff @(posedge clk_i) begin
    if (wr_data) begin
      transmit_holding_reg <= wb_dat_i[7:0] & byte_mask;
    end
    if (rx_done) begin
      receive_buffer_reg <= rx_byte;
    end
  end

  // Data ready and error bits; a new event wins over a read clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_err_reg <= uart_pkg::LSR_ERR_RESET;
    end else begin
      if (rx_done) begin
        line_err_reg[uart_pkg::LSR_DR] <= 1'b1;
      end else if (rd_data) begin
        line_err_reg[uart_pkg::LSR_DR] <= 1'b0;
      end
      if (rx_done && (line_err_reg[uart_pkg::LSR_DR] || rx_frame_err)) begin
        line_err_reg[4:1] <= line_err_reg[4:1] |
          {1'b0, rx_frame_err, 1'b0, line_err_reg[uart_pkg::LSR_DR]};
      end else if (rd_lsr) begin
        line_err_reg[4:1] <= 4'h0;
      end
    end
  end
  assign lsr_value = {1'b0, tx_all_empty_flag_reg, tx_holding_empty_flag_reg, line_err_reg};

  // ----------------------------------------------------------------------
  // Modem inputs, deltas and outputs.
  // ----------------------------------------------------------------------
  assign modem_live = modem_control_reg[uart_pkg::MCR_LOOP] ?
    {modem_control_reg[uart_pkg::MCR_USER_OUTPUT_TWO_N], modem_control_reg[uart_pkg::MCR_USER_OUTPUT_ONE_N],
     modem_control_reg[uart_pkg::MCR_DTR], modem_control_reg[uart_pkg::MCR_RTS]} :
    {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};

  // Change detection; ring counts its trailing edge only.
  always_ff @(posedge clk_i) begin
    modem_prev_reg <= modem_live;
    if (rst_i) begin
      msr_delta_reg <= uart_pkg::MSR_DELTA_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (i == 2 ? (modem_prev_reg[i] && !modem_live[i]) : (modem_prev_reg[i] != modem_live[i])) begin
          msr_delta_reg[i] <= 1'b1;
        end else if (rd_msr) begin
          msr_delta_reg[i] <= 1'b0;
        end
      end
    end
  end
  assign msr_value = {modem_live, msr_delta_reg};

  // Outputs are inverted control bits; loop mode parks them inactive.
  assign rts_n_o = !(modem_control_reg[uart_pkg::MCR_RTS] && !modem_control_reg[uart_pkg::MCR_LOOP]);
  assign dtr_n_o = !(modem_control_reg[uart_pkg::MCR_DTR] && !modem_control_reg[uart_pkg::MCR_LOOP]);
  assign user_output_one_n_o = !(modem_control_reg[uart_pkg::MCR_USER_OUTPUT_ONE_N] && !modem_control_reg[uart_pkg::MCR_LOOP]);
  assign user_output_two_n_o = !(modem_control_reg[uart_pkg::MCR_USER_OUTPUT_TWO_N] && !modem_control_reg[uart_pkg::MCR_LOOP]);

  // ----------------------------------------------------------------------
  // Interrupt priority.
  // ----------------------------------------------------------------------
  // Transmit-empty source: set on holding empty, cleared by id read or write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_holding_empty_flag_int_reg <= 1'b1;
    end else if (wr_data) begin
      tx_holding_empty_flag_int_reg <= 1'b0;
    end else if (tx_load) begin
      tx_holding_empty_flag_int_reg <= 1'b1;
    end else if (rd_iir && iir_code == uart_pkg::IIR_TX_HOLDING_EMPTY_FLAG) begin
      tx_holding_empty_flag_int_reg <= 1'b0;
    end
  end

  // Highest pending enabled source picks the id code.
  always_comb begin
    if (interrupt_enable_reg[uart_pkg::IER_LS] && line_err_reg[4:1] != 4'h0) begin
      iir_code = uart_pkg::IIR_LINE;
    end else if (interrupt_enable_reg[uart_pkg::IER_RX] && line_err_reg[uart_pkg::LSR_DR]) begin
      iir_code = uart_pkg::IIR_RXDATA;
    end else if (interrupt_enable_reg[uart_pkg::IER_TX] && tx_holding_empty_flag_int_reg) begin
      iir_code = uart_pkg::IIR_TX_HOLDING_EMPTY_FLAG;
    end else if (interrupt_enable_reg[uart_pkg::IER_MS] && msr_delta_reg != 4'h0) begin
      iir_code = uart_pkg::IIR_MODEM;
    end else begin
      iir_code = uart_pkg::IIR_NONE;
    end
  end
  assign iir_value = {5'h00, iir_code};
  assign intr_o = !iir_code[0] && modem_control_reg[uart_pkg::MCR_USER_OUTPUT_TWO_N];

  // Read data register, loaded with the request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= '0;
    end else if (rd) begin
      case (addr)
        uart_pkg::ADDR_DATA: dat_reg <= {24'h0, dlab ? divisor_reg[7:0] : receive_buffer_reg};
        uart_pkg::ADDR_IER: dat_reg <= {24'h0, dlab ? divisor_reg[15:8] : {4'h0, interrupt_enable_reg}};
        uart_pkg::ADDR_IIR: dat_reg <= {24'h0, iir_value};
        uart_pkg::ADDR_LCR: dat_reg <= {24'h0, line_control_reg};
        uart_pkg::ADDR_MCR: dat_reg <= {24'h0, modem_control_reg};
        uart_pkg::ADDR_LSR: dat_reg <= {24'h0, lsr_value};
        uart_pkg::ADDR_MSR: dat_reg <= {24'h0, msr_value};
        default: dat_reg <= {24'h0, scratch_reg};
      endcase
    end
  end
  assign wb_dat_o = dat_reg;

endmodule // uart_channel

module uart_shift (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic rx_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  input wire logic brk_i,
  output logic tx_o,
  output logic idle_o,
  output logic done_o,
  output logic [7:0] byte_o,
  output logic ferr_o
);
  logic [9:0] tx_sh_reg;
  logic [3:0] tx_bits_reg;
  logic [3:0] tx_sub_reg;
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_bits_reg;
  logic [3:0] rx_sub_reg;
  logic rx_busy_reg;

  // Transmitter: start, eight data bits, one stop bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh_reg <= 10'h3ff;
      tx_bits_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
    end else if (load_i) begin
      tx_sh_reg <= {1'b1, data_i, 1'b0};
      tx_bits_reg <= 4'ha;
      tx_sub_reg <= 4'h0;
    end else if (tick_i && tx_bits_reg != 4'h0) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_sub_reg == uart_pkg::OVERSAMPLE_LAST) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        tx_bits_reg <= tx_bits_reg - 4'h1;
      end
    end
  end
  assign idle_o = tx_bits_reg == 4'h0;
  assign tx_o = (idle_o ? 1'b1 : tx_sh_reg[0]) && !brk_i;

  // Receiver: sample each bit in its middle.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      rx_busy_reg <= 1'b0;
      rx_sub_reg <= 4'h0;
      rx_bits_reg <= 4'h0;
      ferr_o <= 1'b0;
    end else if (tick_i) begin
      if (!rx_busy_reg) begin
        rx_sub_reg <= 4'h0;
        rx_bits_reg <= 4'h0;
        rx_busy_reg <= !rx_i;
      end else begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_sub_reg == uart_pkg::MID_SAMPLE) begin
          rx_sh_reg <= {rx_i, rx_sh_reg[8:1]};
          rx_bits_reg <= rx_bits_reg + 4'h1;
          if (rx_bits_reg == 4'h0 && rx_i) begin
            rx_busy_reg <= 1'b0;
          end else if (rx_bits_reg == 4'h9) begin
            rx_busy_reg <= 1'b0;
            done_o <= 1'b1;
            byte_o <= rx_sh_reg[8:1];
            ferr_o <= !rx_i;
          end
        end
      end
    end
  end
endmodule // uart_shift
`default_nettype wire

// >>> bench/line_partner.sv
// Behavioural far end of the serial line: modem pins, sender and receiver.
// Assumes 8N1 frames and a bit time of bit_cyc clocks, set by the bench.
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o,
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic ri_n_o,
  output logic dcd_n_o
);
  int bit_cyc = 16;
  logic [7:0] got;
  // Idle line is marking; modem lines start inactive.
  initial begin
    rx_o = 1'b1;
    {cts_n_o, dsr_n_o, ri_n_o, dcd_n_o} = 4'hf;
  end
  // Sends one frame, start bit first and data lsb first.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o <= f[i];
      repeat (bit_cyc) @(posedge clk_i);
    end
  endtask
  // Samples each of the eight transmitted data bits at its middle.
  always begin
    @(negedge tx_i);
    repeat (bit_cyc / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk_i);
      got[i] = tx_i;
    end
  end
endmodule // line_partner
`default_nettype wire

// >>> bench/uart_channel_chk.sv
// Checker of the channel's bus answers, reset levels and bit timing.
// Assumes it is bound to uart_channel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module uart_channel_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic serial_tx_line_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic user_output_one_n_o,
  input wire logic user_output_two_n_o,
  input wire logic intr_o
);
  logic dlab_reg;
  // Follows the divisor access bit, which turns the enable address into the divisor.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dlab_reg <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == {27'h0, uart_pkg::ADDR_LCR}) begin
      dlab_reg <= wb_dat_i[uart_pkg::LCR_DLAB];
    end
  end
  // ------------------------------------------------------------------
  // Sequences.
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A request that the slave has not answered yet.
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  // Reads taken at the identification and enable registers.
  sequence rd_iir_s;
    req_s ##0 (!wb_we_i && wb_sel_i[0] && wb_adr_i == {27'h0, uart_pkg::ADDR_IIR});
  endsequence
  sequence rd_ier_s;
    req_s ##0 (!wb_we_i && !dlab_reg && wb_sel_i[0] && wb_adr_i == {27'h0, uart_pkg::ADDR_IER});
  endsequence
  // The line holds its level for fifteen more cycles.
  sequence hold_s;
    $stable(serial_tx_line_o) [*8] ##1 $stable(serial_tx_line_o) [*7];
  endsequence
  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  a_req_answered: assert property (req_s |=> wb_ack_o != wb_err_o)
    else $error("Request not answered one cycle later.");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held past one cycle.");
  a_err_single: assert property (wb_err_o |=> !wb_err_o)
    else $error("Error held past one cycle.");
  a_idle_silent: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("Answer without a request.");
  a_ier_upper_zero: assert property (rd_ier_s |=> wb_ack_o && wb_dat_o[7:4] == 4'h0)
    else $error("Enable register upper bits not zero.");
  a_iir_upper_zero: assert property (rd_iir_s |=> wb_ack_o && wb_dat_o[7:3] == 5'h0)
    else $error("Identification upper bits not zero.");
  a_rdata_narrow: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("Read data above bit 7 not zero.");
  a_bit_hold: assert property ($changed(serial_tx_line_o) |=> hold_s)
    else $error("Serial bit shorter than sixteen cycles.");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> serial_tx_line_o && rts_n_o
    && dtr_n_o && user_output_one_n_o && user_output_two_n_o && !intr_o && !wb_ack_o)
    else $error("Outputs not inactive after reset.");
endmodule // uart_channel_chk
bind uart_channel uart_channel_chk u_uart_channel_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o),
  .serial_tx_line_o(serial_tx_line_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
  .user_output_one_n_o(user_output_one_n_o), .user_output_two_n_o(user_output_two_n_o),
  .intr_o(intr_o));
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench of the serial channel over classic Wishbone.
// Assumes the line partner model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic err; logic chk; logic [31:0] dat;} exp_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, rx, tx, cts_n, dsr_n, ri_n, dcd_n;
  logic rts_n, dtr_n, user_output_one_n_n, user_output_two_n_n, intr;
  exp_t exp_q[$];
  int n_fail = 0;
  int tests_run = 0;
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  uart_channel u_uart_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'h1), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .serial_rx_line_i(rx), .serial_tx_line_o(tx), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
    .ri_n_i(ri_n), .dcd_n_i(dcd_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
    .user_output_one_n_o(user_output_one_n_n), .user_output_two_n_o(user_output_two_n_n), .intr_o(intr));
  line_partner u_line_partner (.clk_i(clk_i), .tx_i(tx), .rx_o(rx), .cts_n_o(cts_n),
    .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n));
  // Compares one result and counts it.
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One classic cycle; the expected answer is queued first.
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
    input logic chk, input logic [7:0] e, input logic err);
    int n;
    exp_q.push_back({err, chk, 24'h0, e});
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {27'h0, a} | {31'h0, err};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0, 8'h0, 1'b0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0, 1'b1, e, 1'b0);
  endtask
  // Takes the oldest note whenever the slave answers.
  always @(negedge clk_i) begin
    exp_t e;
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      e = exp_q.pop_front();
      check32({31'h0, wb_err_o}, {31'h0, e.err});
      if (e.chk)
        check32(wb_dat_o, e.dat);
    end
  end
  // Main sequence.
  initial begin
    logic [7:0] b;
    int n;
    int dv [7] = '{3072, 1142, 3840, 1745, 4, 5, 1};
    b = 8'($urandom(32'hb082));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      check32({27'h0, tx, rts_n, dtr_n, user_output_one_n_n, user_output_two_n_n}, 32'h1f);
      rd(uart_pkg::ADDR_IER, 8'h00);
      rd(uart_pkg::ADDR_IIR, 8'h01);
      rd(uart_pkg::ADDR_MCR, 8'h00);
      rd(uart_pkg::ADDR_LSR, 8'h60);
      rd(uart_pkg::ADDR_MSR, {k[0], 2'h0, k[0], 4'h0});
      if (k == 0) begin
        wr(uart_pkg::ADDR_MCR, 8'h0f);
        check32({28'h0, rts_n, dtr_n, user_output_one_n_n, user_output_two_n_n}, 32'h0);
        wr(uart_pkg::ADDR_IER, 8'hff);
        rd(uart_pkg::ADDR_IER, 8'h0f);
        check32({31'h0, intr}, 32'h1);
        rd(uart_pkg::ADDR_IIR, 8'h02);
        rd(uart_pkg::ADDR_IIR, 8'h01);
        u_line_partner.cts_n_o <= 1'b0;
        u_line_partner.dcd_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        rd(uart_pkg::ADDR_IIR, 8'h00);
        rd(uart_pkg::ADDR_MSR, 8'h99);
        rd(uart_pkg::ADDR_MSR, 8'h90);
        check32({31'h0, intr}, 32'h0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
      end
    end
    for (int i = 0; i < 7; i++) begin
      wr(uart_pkg::ADDR_LCR, 8'h80);
      wr(uart_pkg::ADDR_DATA, dv[i][7:0]);
      wr(uart_pkg::ADDR_IER, dv[i][15:8]);
      rd(uart_pkg::ADDR_DATA, dv[i][7:0]);
      rd(uart_pkg::ADDR_IER, dv[i][15:8]);
      wr(uart_pkg::ADDR_LCR, 8'h03);
      if (dv[i] <= 5) begin
        u_line_partner.bit_cyc = 16 * dv[i];
        b = (8'($urandom) & 8'hfc) | 8'h01;
        wr(uart_pkg::ADDR_DATA, b);
        n = 0;
        while (tx !== 1'b0 && n < 200) begin
          @(posedge clk_i);
          n++;
        end
        n = 0;
        while (tx === 1'b0 && n < 200) begin
          @(posedge clk_i);
          n++;
        end
        // The start bit follows the free-running baud phase, so the high first bit is timed.
        n = 0;
        while (tx === 1'b1 && n < 200) begin
          @(posedge clk_i);
          n++;
        end
        check32(n, 16 * dv[i]);
        repeat (10 * 16 * dv[i]) @(posedge clk_i);
        check32({24'h0, u_line_partner.got}, {24'h0, b});
      end
    end
    wr(uart_pkg::ADDR_MCR, 8'h08);
    wr(uart_pkg::ADDR_IER, 8'h01);
    b = 8'($urandom);
    u_line_partner.send(b);
    repeat (20) @(posedge clk_i);
    rd(uart_pkg::ADDR_LSR, 8'h61);
    rd(uart_pkg::ADDR_IIR, 8'h04);
    check32({31'h0, intr}, 32'h1);
    rd(uart_pkg::ADDR_DATA, b);
    rd(uart_pkg::ADDR_IIR, 8'h01);
    check32({31'h0, intr}, 32'h0);
    bus(1'b0, 5'h1c, 8'h0, 1'b0, 8'h0, 1'b1);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
